// ==== shared/cpfs_map.vh ====
/*
 * cpfs_map.vh: constants of the pipeline fetch and stall block:
 * widths, phase codes, select codes and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef CPFS_MAP_VH
`define CPFS_MAP_VH

`define CPFS_IP_W 22
`define CPFS_RESET_IP 22'h000000
`define CPFS_DATA_W 32
`define CPFS_INSN_W 32
`define CPFS_QUEUE_DEPTH 4
`define CPFS_QUEUE_AW 2
`define CPFS_RPT_W 8
`define CPFS_REG_W 4
// instruction word fields
`define CPFS_OPC_HI 31
`define CPFS_OPC_LO 28
`define CPFS_DST_HI 27
`define CPFS_DST_LO 24
`define CPFS_SRC_HI 23
`define CPFS_SRC_LO 20
`define CPFS_CONST_HI 19
`define CPFS_CONST_LO 0
`define CPFS_CONST_W 20
// opcodes
`define CPFS_OP_NOP 4'h0
`define CPFS_OP_ALU 4'h1
`define CPFS_OP_LOAD 4'h2
`define CPFS_OP_STORE 4'h3
`define CPFS_OP_BRANCH 4'h4
`define CPFS_OP_REPEAT 4'h5
`define CPFS_OP_PREAD 4'h6
// select codes for external decode
`define CPFS_SEL_W 3
`define CPFS_SEL_NONE 3'h0
`define CPFS_SEL_PFETCH 3'h1
`define CPFS_SEL_PDATA 3'h2
`define CPFS_SEL_DREAD 3'h4
`define CPFS_SEL_DWRITE 3'h4
`define CPFS_SEL_DW 3'h4
`define CPFS_FRONT_DEPTH 3
`define CPFS_BACK_DEPTH 5
`define CPFS_BACK_RD1 1
`define CPFS_BACK_RD2 2
`define CPFS_BACK_EXE 3
`define CPFS_BACK_WR 4
`define CPFS_ONE_IP 22'h000001
`define CPFS_ONE_RPT 8'h01
`define CPFS_ZERO_RPT 8'h00

`endif

// ==== rtl/cpfs_fetch_queue.v ====
/*
 * cpfs_fetch_queue.v: small instruction queue between the fetch and
 * decode halves; each entry carries the word and its address.
 * Assumes a single clock and that the caller never pushes when full.
 */
`timescale 1ns/1ps
`include "cpfs_map.vh"

module cpfs_fetch_queue #(
	parameter WIDTH = 54,
	parameter DEPTH = `CPFS_QUEUE_DEPTH,
	parameter AW = `CPFS_QUEUE_AW
) (
	input wire clock,
	input wire rst,
	input wire flush,
	input wire push,
	input wire [WIDTH-1:0] pushData,
	input wire pop,
	output reg [WIDTH-1:0] headData,
	output wire empty,
	output wire full
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] count_r;
	wire doPush = push && !full;
	wire doPop = pop && !empty;
	wire [AW-1:0] rdNext = rdPtr_r + {{(AW-1){1'b0}}, 1'b1};

	assign empty = (count_r == {(AW+1){1'b0}});
	assign full = (count_r == DEPTH[AW:0]);

	// storage write, no reset needed
	always @(posedge clock) begin
		if (doPush) begin
			mem[wrPtr_r] <= pushData;
		end
	end

	// pointers; flush drops everything on a discontinuity
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else if (flush) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (doPush) begin
				wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (doPop) begin
				rdPtr_r <= rdNext;
			end
			if (doPush && !doPop) begin
				count_r <= count_r + {{AW{1'b0}}, 1'b1};
			end else if (doPop && !doPush) begin
				count_r <= count_r - {{AW{1'b0}}, 1'b1};
			end
		end
	end

	// registered head: look through to the next entry after a pop
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			headData <= {WIDTH{1'b0}};
		end else if (doPush && (empty || (doPop && count_r == {{AW{1'b0}}, 1'b1}))) begin
			headData <= pushData;
		end else if (doPop) begin
			headData <= mem[rdNext];
		end else if (!empty) begin
			headData <= mem[rdPtr_r];
		end
	end
endmodule

// ==== rtl/cpfs_pipeline.v ====
/*
 * cpfs_pipeline.v: fetch and stall control of an eight phase core
 * pipeline: fetch address generation, instruction queue, decode,
 * operand read phases, write phase, repeat and interlock.
 * Assumes memories answer combinationally in the same cycle unless
 * they drop their ready input; all inputs synchronous to clock.
 */
// Functional notes
// RL1 - With a full pipeline the instruction pointer holds the address of the instruction now in decode 2; here it shows that address one clock later.
// RL2 - Addresses for instruction fetch and program-space data reads go out on the program fetch address bus.
// RL3 - Fetched words are queued, decoded and passed on as commands and constants to other units.
// RL4 - In the operand-address phase the read address of any memory operand is driven out.
// RL5 - In the operand-fetch phase the data addressed one phase earlier is captured.
// RL6 - A slow memory or peripheral holds its ready input low to add wait states.
// RL7 - A wait request in fetch 1, operand-address or write freezes the affected part of the pipeline.
// RL8 - Idle cycles are inserted so no instruction reads a register before an earlier one updates it.
// RL9 - The repeat prefix loads the repeat count and the next instruction runs once plus that many times.
// RL10 - Branches, calls, interrupts, returns and repetition fetch from a nonsequential address; here only branches and interrupts redirect fetch.
// RL11 - Select outputs tell external logic which kind of access is under way.
// RL12 - Each instruction goes through fetch 1, fetch 2, decode 1, decode 2, read 1, read 2, execute, write.
// RL13 - Program not ready freezes fetch 1 to decode 1; empty queue or data not ready freezes decode 2 to write; here empty queue lets read 1 to write drain.
// RL14 - In the write phase the destination address and data go out to memory.
// RL15 - An unfrozen section moves each instruction on by one phase per clock.
`timescale 1ns/1ps
`include "cpfs_map.vh"

module cpfs_pipeline #(
	parameter IPW = `CPFS_IP_W,
	parameter DW = `CPFS_DATA_W,
	parameter RPTW = `CPFS_RPT_W
) (
	input wire clock,
	input wire rst,
	input wire progReady,
	input wire dataReady,
	input wire [DW-1:0] programReadDataBus,
	input wire [DW-1:0] dataReadBus,
	input wire interruptReq,
	input wire [IPW-1:0] interruptVector,
	output reg [IPW-1:0] programFetchAddressBus,
	output reg progReadStrobe,
	output reg [IPW-1:0] dataReadAddress,
	output reg dataReadStrobe,
	output reg [IPW-1:0] dataWriteAddress,
	output reg [DW-1:0] dataWriteData,
	output reg dataWriteStrobe,
	output reg [`CPFS_SEL_W-1:0] progSelect,
	output reg [`CPFS_SEL_W-1:0] dataSelect,
	output reg [IPW-1:0] instructionPointer,
	output reg [3:0] execCommand,
	output reg [`CPFS_CONST_W-1:0] execConstant,
	output reg [DW-1:0] operandData,
	output reg execValid,
	output reg [RPTW-1:0] repeatCountRegister,
	output reg frontFrozen,
	output reg backFrozen
);
	localparam QW = IPW + DW;
	// fetch section states, one-hot
	localparam FS_RUN = 2'b01;
	localparam FS_REDIRECT = 2'b10;

	reg [1:0] fState_r;
	reg [IPW-1:0] fetchIp_r;
	// fetch 2 and decode 1 stage registers
	reg f2Valid_r, d1Valid_r;
	reg [IPW-1:0] f2Ip_r, d1Ip_r;
	reg [DW-1:0] f2Word_r, d1Word_r;
	// back section: decode 2, read 1, read 2, execute, write
	reg bValid_r [0:`CPFS_BACK_DEPTH-1];
	reg [DW-1:0] bWord_r [0:`CPFS_BACK_DEPTH-1];
	reg [IPW-1:0] bIp_r [0:`CPFS_BACK_DEPTH-1];
	reg [DW-1:0] exData_r;
	reg repeating_r;
	reg pendingRedirect_r;
	reg irqTaken_r;
	reg [IPW-1:0] redirectIp_r;
	integer i;
	integer j;

	wire qEmpty, qFull;
	wire [QW-1:0] qHead;
	wire [3:0] d2Op = bWord_r[0][`CPFS_OPC_HI:`CPFS_OPC_LO];
	wire [3:0] d2Src = bWord_r[0][`CPFS_SRC_HI:`CPFS_SRC_LO];
	wire [3:0] r1Op = bWord_r[`CPFS_BACK_RD1][`CPFS_OPC_HI:`CPFS_OPC_LO];
	wire [3:0] exOp = bWord_r[`CPFS_BACK_EXE][`CPFS_OPC_HI:`CPFS_OPC_LO];
	wire [3:0] wrOp = bWord_r[`CPFS_BACK_WR][`CPFS_OPC_HI:`CPFS_OPC_LO];
	wire r1Reads = bValid_r[`CPFS_BACK_RD1] && (r1Op == `CPFS_OP_LOAD || r1Op == `CPFS_OP_PREAD);
	wire wrStores = bValid_r[`CPFS_BACK_WR] && (wrOp == `CPFS_OP_STORE);
	wire r1PRead = bValid_r[`CPFS_BACK_RD1] && (r1Op == `CPFS_OP_PREAD);

	// RL7 RL13 freeze terms
	// fetch half waits on program ready unless the port is lent to a data read
	// stall terms come from the strobes on the bus, so a held request freezes its own section
	wire rd2PRead = progReadStrobe && progSelect == `CPFS_SEL_PDATA;
	wire frontStall = (progReadStrobe && progSelect == `CPFS_SEL_PFETCH && !progReady) || qFull;
	wire backStall = ((dataReadStrobe || dataWriteStrobe) && !dataReady) || (rd2PRead && !progReady);

	// RL8 register interlock
	// decode 2 holds while any later writer targets its source register
	reg hazard;
	always @* begin
		hazard = 1'b0;
		for (j = 1; j < `CPFS_BACK_DEPTH; j = j + 1) begin
			if (bValid_r[j] && bWord_r[j][`CPFS_OPC_HI:`CPFS_OPC_LO] != `CPFS_OP_STORE
				&& bWord_r[j][`CPFS_OPC_HI:`CPFS_OPC_LO] != `CPFS_OP_NOP
				&& bWord_r[j][`CPFS_DST_HI:`CPFS_DST_LO] == d2Src) begin
				hazard = 1'b1;
			end
		end
	end
	wire d2Valid = bValid_r[0];
	wire d2Hold = d2Valid && (hazard || repeating_r);
	// RL13 empty queue leaves decode 2 unfilled, the back half idles
	wire qPop = !backStall && !qEmpty && (!d2Valid || !d2Hold);
	wire exBranch = !backStall && bValid_r[`CPFS_BACK_EXE] && exOp == `CPFS_OP_BRANCH;
	// a held request is taken once, else the vector would be refetched forever
	wire takeIrq = interruptReq && !irqTaken_r && !pendingRedirect_r && !exBranch;
	wire redirect = exBranch || takeIrq;
	wire [IPW-1:0] redirectTarget = exBranch ?
		bWord_r[`CPFS_BACK_EXE][IPW-1:0] : interruptVector;
	// a fetch completes when its address stands on the bus with ready high
	wire fetchGo = (fState_r == FS_RUN) && progReadStrobe && progSelect == `CPFS_SEL_PFETCH
		&& progReady && !qFull && !redirect;
	wire fetchRunNxt = (fState_r == FS_REDIRECT) || ((fState_r == FS_RUN) && !redirect);
	wire [IPW-1:0] fetchIpNxt = (fState_r == FS_REDIRECT) ? redirectIp_r :
		(fetchGo ? fetchIp_r + `CPFS_ONE_IP : fetchIp_r);
	wire qPush = d1Valid_r && !frontStall && !redirect;

	cpfs_fetch_queue #(
		.WIDTH(QW),
		.DEPTH(`CPFS_QUEUE_DEPTH),
		.AW(`CPFS_QUEUE_AW)
	) u_queue (
		.clock(clock),
		.rst(rst),
		.flush(redirect),
		.push(qPush),
		.pushData({d1Ip_r, d1Word_r}),
		.pop(qPop),
		.headData(qHead),
		.empty(qEmpty),
		.full(qFull)
	);

	// RL2 RL10 fetch address generation and redirect
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			fState_r <= FS_RUN;
			fetchIp_r <= `CPFS_RESET_IP;
			pendingRedirect_r <= 1'b0;
			irqTaken_r <= 1'b0;
			redirectIp_r <= `CPFS_RESET_IP;
		end else begin
			if (takeIrq) begin
				irqTaken_r <= 1'b1;
			end else if (!interruptReq) begin
				irqTaken_r <= 1'b0;
			end
			case (fState_r)
			FS_RUN: begin
				if (redirect) begin
					fState_r <= FS_REDIRECT;
					redirectIp_r <= redirectTarget;
					pendingRedirect_r <= 1'b1;
				end else if (fetchGo) begin
					fetchIp_r <= fetchIp_r + `CPFS_ONE_IP;
				end
			end
			FS_REDIRECT: begin
				// one idle cycle lets the flush settle before the new stream
				fState_r <= FS_RUN;
				fetchIp_r <= redirectIp_r;
				pendingRedirect_r <= 1'b0;
			end
			default: begin
				fState_r <= FS_RUN;
			end
			endcase
		end
	end

	// RL12 RL15 fetch 1 to decode 1 advance
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			f2Valid_r <= 1'b0;
			d1Valid_r <= 1'b0;
			f2Ip_r <= `CPFS_RESET_IP;
			d1Ip_r <= `CPFS_RESET_IP;
			f2Word_r <= {DW{1'b0}};
			d1Word_r <= {DW{1'b0}};
		end else if (redirect) begin
			f2Valid_r <= 1'b0;
			d1Valid_r <= 1'b0;
		end else if (!frontStall) begin
			f2Valid_r <= fetchGo;
			f2Ip_r <= programFetchAddressBus;
			f2Word_r <= programReadDataBus;
			d1Valid_r <= f2Valid_r;
			d1Ip_r <= f2Ip_r;
			d1Word_r <= f2Word_r;
		end
	end

	// RL12 RL15 decode 2 to write advance, RL9 repeat control
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			for (i = 0; i < `CPFS_BACK_DEPTH; i = i + 1) begin
				bValid_r[i] <= 1'b0;
				bWord_r[i] <= {DW{1'b0}};
				bIp_r[i] <= `CPFS_RESET_IP;
			end
			repeatCountRegister <= `CPFS_ZERO_RPT;
			repeating_r <= 1'b0;
			exData_r <= {DW{1'b0}};
		end else if (!backStall) begin
			for (i = 2; i < `CPFS_BACK_DEPTH; i = i + 1) begin
				bValid_r[i] <= bValid_r[i-1];
				bWord_r[i] <= bWord_r[i-1];
				bIp_r[i] <= bIp_r[i-1];
			end
			// RL5 operand capture while read 2 holds the strobe on the bus
			if (rd2PRead) begin
				exData_r <= programReadDataBus;
			end else if (dataReadStrobe) begin
				exData_r <= dataReadBus;
			end
			// RL9 repeat: issue a copy while the count runs down
			if (repeating_r && d2Valid && !hazard) begin
				bValid_r[1] <= 1'b1;
				bWord_r[1] <= bWord_r[0];
				bIp_r[1] <= bIp_r[0];
				if (repeatCountRegister == `CPFS_ZERO_RPT) begin
					repeating_r <= 1'b0;
					bValid_r[0] <= qPop;
					bWord_r[0] <= qHead[DW-1:0];
					bIp_r[0] <= qHead[QW-1:DW];
				end else begin
					repeatCountRegister <= repeatCountRegister - `CPFS_ONE_RPT;
				end
			end else if (d2Hold) begin
				// RL8 bubble into read 1
				bValid_r[1] <= 1'b0;
			end else begin
				bValid_r[1] <= d2Valid;
				bWord_r[1] <= bWord_r[0];
				bIp_r[1] <= bIp_r[0];
				bValid_r[0] <= qPop;
				bWord_r[0] <= qHead[DW-1:0];
				bIp_r[0] <= qHead[QW-1:DW];
				if (d2Valid && d2Op == `CPFS_OP_REPEAT) begin
					repeatCountRegister <= bWord_r[0][RPTW-1:0];
				end
				// the instruction after the prefix runs once then repeats
				if (d2Valid && d2Op == `CPFS_OP_REPEAT && bWord_r[0][RPTW-1:0] != `CPFS_ZERO_RPT) begin
					repeating_r <= 1'b1;
				end
			end
			if (exBranch) begin
				// discard younger work behind the branch
				bValid_r[0] <= 1'b0;
				bValid_r[1] <= 1'b0;
				bValid_r[2] <= 1'b0;
				bValid_r[`CPFS_BACK_EXE] <= 1'b0;
				repeating_r <= 1'b0;
			end
		end
	end

	// registered outputs: buses, selects, decode results
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			programFetchAddressBus <= `CPFS_RESET_IP;
			progReadStrobe <= 1'b0;
			progSelect <= `CPFS_SEL_NONE;
			dataReadAddress <= `CPFS_RESET_IP;
			dataReadStrobe <= 1'b0;
			dataSelect <= `CPFS_SEL_NONE;
			dataWriteAddress <= `CPFS_RESET_IP;
			dataWriteData <= {DW{1'b0}};
			dataWriteStrobe <= 1'b0;
			instructionPointer <= `CPFS_RESET_IP;
			execCommand <= `CPFS_OP_NOP;
			execConstant <= {`CPFS_CONST_W{1'b0}};
			operandData <= {DW{1'b0}};
			execValid <= 1'b0;
			frontFrozen <= 1'b0;
			backFrozen <= 1'b0;
		end else begin
			frontFrozen <= frontStall;
			backFrozen <= backStall || (!d2Valid && qEmpty);
			// RL2 RL4 program port: data read wins over sequential fetch
			// RL7 a waiting program data read keeps its address
			if (!(rd2PRead && backStall)) begin
				if (r1PRead && !backStall) begin
					programFetchAddressBus <= bWord_r[`CPFS_BACK_RD1][IPW-1:0];
					progReadStrobe <= 1'b1;
					// RL11 select for program-space data
					progSelect <= `CPFS_SEL_PDATA;
				end else begin
					programFetchAddressBus <= fetchIpNxt;
					progReadStrobe <= fetchRunNxt;
					progSelect <= fetchRunNxt ? `CPFS_SEL_PFETCH : `CPFS_SEL_NONE;
				end
			end
			// RL7 data requests stand while the back half is frozen
			if (!backStall) begin
				// RL4 data read address in read 1
				dataReadStrobe <= r1Reads && !r1PRead;
				dataReadAddress <= bWord_r[`CPFS_BACK_RD1][IPW-1:0];
				// RL14 write phase address and data
				dataWriteStrobe <= wrStores;
				dataWriteAddress <= bWord_r[`CPFS_BACK_WR][IPW-1:0];
				dataWriteData <= exData_r;
				// RL11 data select for any data access, code 3'h4 for reads and writes alike
				if (wrStores) begin
					dataSelect <= `CPFS_SEL_DW;
				end else if (r1Reads && !r1PRead) begin
					dataSelect <= `CPFS_SEL_DREAD;
				end else begin
					dataSelect <= `CPFS_SEL_NONE;
				end
			end
			// RL1 pointer follows decode 2
			if (d2Valid) begin
				instructionPointer <= bIp_r[0];
			end
			// RL3 commands and constants to the other units
			execValid <= !backStall && bValid_r[`CPFS_BACK_EXE];
			execCommand <= exOp;
			execConstant <= bWord_r[`CPFS_BACK_EXE][`CPFS_CONST_HI:`CPFS_CONST_LO];
			operandData <= exData_r;
		end
	end
endmodule

// ==== sim/cpfs_pipeline_sva.sv ====
/*
 * cpfs_pipeline_sva.sv: assertions on the ports of the pipeline block.
 * Assumes one clock and an async active-high reset; bound below.
 */
`timescale 1ns/1ps
`include "cpfs_map.vh"

module cpfs_pipeline_sva #(
	parameter IPW = 22
) (
	input wire clock,
	input wire rst,
	input wire progReady,
	input wire dataReady,
	input wire interruptReq,
	input wire [IPW-1:0] interruptVector,
	input wire [IPW-1:0] programFetchAddressBus,
	input wire progReadStrobe,
	input wire [IPW-1:0] dataReadAddress,
	input wire dataReadStrobe,
	input wire dataWriteStrobe,
	input wire [`CPFS_SEL_W-1:0] progSelect,
	input wire [`CPFS_SEL_W-1:0] dataSelect,
	input wire frontFrozen,
	input wire backFrozen
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// program and data wait requests
	sequence fetchWait;
		progReadStrobe && !progReady && progSelect == `CPFS_SEL_PFETCH;
	endsequence
	sequence preadWait;
		progReadStrobe && !progReady && progSelect == `CPFS_SEL_PDATA;
	endsequence
	sequence dataWait;
		(dataReadStrobe || dataWriteStrobe) && !dataReady;
	endsequence
	rst_fetch_a: assert property ($fell(rst) |=> progReadStrobe && programFetchAddressBus == '0
		&& progSelect == `CPFS_SEL_PFETCH) else $error("first fetch after reset wrong");
	front_freeze_a: assert property (fetchWait |=> frontFrozen)
		else $error("front not frozen on program wait");
	pread_hold_a: assert property (preadWait |=> progReadStrobe && $stable(programFetchAddressBus))
		else $error("program data address moved in wait");
	rd_hold_a: assert property (dataReadStrobe && !dataReady |=> dataReadStrobe && $stable(dataReadAddress))
		else $error("read address moved in wait");
	back_freeze_a: assert property (dataWait |=> backFrozen)
		else $error("back not frozen on data wait");
	data_sel_a: assert property (dataReadStrobe || dataWriteStrobe |-> dataSelect == `CPFS_SEL_DW)
		else $error("data select missing");
	prog_sel_a: assert property (progReadStrobe == (progSelect != `CPFS_SEL_NONE))
		else $error("program select disagrees with strobe");
	irq_redir_a: assert property ($rose(interruptReq) |-> ##[1:20]
		(progReadStrobe && programFetchAddressBus == interruptVector)) else $error("no fetch from vector");
endmodule

bind cpfs_pipeline cpfs_pipeline_sva #(.IPW(IPW)) u_sva (.clock(clock), .rst(rst), .progReady(progReady),
	.dataReady(dataReady), .interruptReq(interruptReq), .interruptVector(interruptVector),
	.programFetchAddressBus(programFetchAddressBus), .progReadStrobe(progReadStrobe),
	.dataReadAddress(dataReadAddress), .dataReadStrobe(dataReadStrobe), .dataWriteStrobe(dataWriteStrobe),
	.progSelect(progSelect), .dataSelect(dataSelect), .frontFrozen(frontFrozen), .backFrozen(backFrozen));

// ==== sim/cpfs_mem_model.sv ====
/*
 * cpfs_mem_model.sv: program and data memory on the far side.
 * Assumes the bench loads the arrays and drives the stall wishes.
 */
`timescale 1ns/1ps

module cpfs_mem_model (
	input wire clock,
	input wire progStall,
	input wire dataStall,
	input wire [21:0] programFetchAddressBus,
	input wire progReadStrobe,
	input wire [21:0] dataReadAddress,
	input wire dataReadStrobe,
	input wire [21:0] dataWriteAddress,
	input wire [31:0] dataWriteData,
	input wire dataWriteStrobe,
	output wire [31:0] programReadDataBus,
	output wire [31:0] dataReadBus,
	output wire progReady,
	output wire dataReady
);
	reg [31:0] pmem [0:255];
	reg [31:0] dmem [0:255];
	reg [31:0] lastProg_r = 32'h00000000;
	reg [31:0] lastData_r = 32'h00000000;
	assign progReady = !progStall;
	assign dataReady = !dataStall;
	// idle or waiting bus shows the inverse of its last value, so it toggles each cycle
	assign programReadDataBus = (progReadStrobe && progReady) ? pmem[programFetchAddressBus[7:0]] : ~lastProg_r;
	assign dataReadBus = (dataReadStrobe && dataReady) ? dmem[dataReadAddress[7:0]] : ~lastData_r;
	always @(posedge clock) begin
		lastProg_r <= programReadDataBus;
		lastData_r <= dataReadBus;
		if (dataWriteStrobe && dataReady)
			dmem[dataWriteAddress[7:0]] <= dataWriteData;
	end
endmodule

// ==== sim/cpfs_pipeline_tb.sv ====
/*
 * cpfs_pipeline_tb.sv: runs a small program with and without wait states
 * against an instruction-level model, then takes an interrupt.
 * Assumes the memory model and the bound checker.
 */
`timescale 1ns/1ps
`include "cpfs_map.vh"

module cpfs_pipeline_tb;
	reg clock, rst, progStall, dataStall, interruptReq, seenIrq;
	reg [21:0] interruptVector;
	reg [15:0] rnd = 16'hADB3;
	wire [7:0] repeatCount;
	wire progReady, dataReady, progReadStrobe, dataReadStrobe, dataWriteStrobe, execValid;
	wire [31:0] programReadDataBus, dataReadBus, dataWriteData, operandData;
	wire [21:0] programFetchAddressBus, dataReadAddress, dataWriteAddress;
	wire [3:0] execCommand;
	wire [19:0] execConstant;
	integer fails, n_tests, runPass, i, cyc;
	logic [3:0] qCmd[$];
	logic [19:0] qK[$];
	logic [31:0] qOp[$];
	logic [21:0] qWr[$];

	cpfs_pipeline u_cpfs_pipeline (.clock(clock), .rst(rst), .progReady(progReady), .dataReady(dataReady),
		.programReadDataBus(programReadDataBus), .dataReadBus(dataReadBus), .interruptReq(interruptReq),
		.interruptVector(interruptVector), .programFetchAddressBus(programFetchAddressBus),
		.progReadStrobe(progReadStrobe), .dataReadAddress(dataReadAddress), .dataReadStrobe(dataReadStrobe),
		.dataWriteAddress(dataWriteAddress), .dataWriteData(dataWriteData), .dataWriteStrobe(dataWriteStrobe),
		.progSelect(), .dataSelect(), .instructionPointer(), .execCommand(execCommand),
		.execConstant(execConstant), .operandData(operandData), .execValid(execValid),
		.repeatCountRegister(repeatCount), .frontFrozen(), .backFrozen());
	cpfs_mem_model u_cpfs_mem_model (.clock(clock), .progStall(progStall), .dataStall(dataStall),
		.programFetchAddressBus(programFetchAddressBus), .progReadStrobe(progReadStrobe),
		.dataReadAddress(dataReadAddress), .dataReadStrobe(dataReadStrobe), .dataWriteAddress(dataWriteAddress),
		.dataWriteData(dataWriteData), .dataWriteStrobe(dataWriteStrobe), .programReadDataBus(programReadDataBus),
		.dataReadBus(dataReadBus), .progReady(progReady), .dataReady(dataReady));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function [31:0] ins(input [3:0] op, input [3:0] dst, input [3:0] src, input [19:0] k);
		ins = {op, dst, src, k};
	endfunction
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one executed instruction of the reference stream
	task push(input [31:0] w);
		qCmd.push_back(w[31:28]);
		qK.push_back(w[19:0]);
		qOp.push_back(w[31:28] == `CPFS_OP_PREAD ? u_cpfs_mem_model.pmem[w[7:0]] : u_cpfs_mem_model.dmem[w[7:0]]);
		if (w[31:28] == `CPFS_OP_STORE)
			qWr.push_back(w[21:0]);
	endtask
	task build_expect;
		integer pc, reps, n, k;
		reg [31:0] w;
		pc = 0;
		reps = 0;
		for (n = 0; n < 40; n = n + 1) begin
			w = u_cpfs_mem_model.pmem[pc];
			for (k = 0; k <= reps; k = k + 1)
				push(w);
			reps = (w[31:28] == `CPFS_OP_REPEAT) ? w[7:0] : 0;
			if (w[31:28] == `CPFS_OP_BRANCH) begin
				if (w[7:0] == pc)
					break;
				pc = w[7:0];
			end else
				pc = pc + 1;
		end
	endtask

	// compare each result with the model; wrong-path results never reach here
	always @(posedge clock) begin
		if (rst === 1'b1)
			seenIrq <= 1'b0;
		if (rst === 1'b0 && execValid === 1'b1) begin
			if (execConstant === 20'h00055)
				seenIrq <= 1'b1;
			if (qCmd.size() > 0) begin
				check("command", {28'h0000000, execCommand}, {28'h0000000, qCmd[0]});
				check("constant", {12'h000, execConstant}, {12'h000, qK[0]});
				if (qCmd[0] == `CPFS_OP_LOAD || qCmd[0] == `CPFS_OP_PREAD)
					check("operand", operandData, qOp[0]);
				void'(qCmd.pop_front());
				void'(qK.pop_front());
				void'(qOp.pop_front());
			end
		end
		if (rst === 1'b0 && dataWriteStrobe === 1'b1 && dataReady && qWr.size() > 0)
			check("write address", {10'h000, dataWriteAddress}, {10'h000, qWr.pop_front()});
	end

	// random wait states in second pass
	always @(posedge clock) begin
		#1;
		rnd = lfsr(rnd);
		progStall = runPass == 1 && rnd[1:0] == 2'h0;
		dataStall = runPass == 1 && rnd[3:2] == 2'h0;
	end

	initial begin
		#(20 * 8000);
		fails = fails + 1;
		report_and_stop;
	end

	initial begin
		fails = 0;
		n_tests = 0;
		rst = 1'b1;
		runPass = 0;
		interruptReq = 1'b0;
		interruptVector = 22'h000050;
		for (i = 0; i < 256; i = i + 1) begin
			u_cpfs_mem_model.pmem[i] = 32'h00000000;
			u_cpfs_mem_model.dmem[i] = 32'h00000000;
		end
		u_cpfs_mem_model.pmem[0] = ins(`CPFS_OP_ALU, 4'h1, 4'h0, 20'h00005);
		u_cpfs_mem_model.pmem[1] = ins(`CPFS_OP_ALU, 4'h2, 4'h1, 20'h00007);
		u_cpfs_mem_model.pmem[2] = ins(`CPFS_OP_LOAD, 4'h3, 4'h0, 20'h00010);
		u_cpfs_mem_model.pmem[3] = ins(`CPFS_OP_ALU, 4'h4, 4'h3, 20'h00001);
		u_cpfs_mem_model.pmem[4] = ins(`CPFS_OP_STORE, 4'h0, 4'h4, 20'h00020);
		u_cpfs_mem_model.pmem[5] = ins(`CPFS_OP_REPEAT, 4'h0, 4'h0, 20'h00003);
		u_cpfs_mem_model.pmem[6] = ins(`CPFS_OP_ALU, 4'h5, 4'h5, 20'h00009);
		u_cpfs_mem_model.pmem[7] = ins(`CPFS_OP_PREAD, 4'h6, 4'h0, 20'h00040);
		u_cpfs_mem_model.pmem[8] = ins(`CPFS_OP_BRANCH, 4'h0, 4'h0, 20'h00030);
		u_cpfs_mem_model.pmem[9] = ins(`CPFS_OP_ALU, 4'h7, 4'h0, 20'h00BAD);
		u_cpfs_mem_model.pmem[48] = ins(`CPFS_OP_REPEAT, 4'h0, 4'h0, 20'h00000);
		u_cpfs_mem_model.pmem[49] = ins(`CPFS_OP_ALU, 4'h8, 4'h0, 20'h00011);
		u_cpfs_mem_model.pmem[50] = ins(`CPFS_OP_LOAD, 4'h9, 4'h0, 20'h00011);
		u_cpfs_mem_model.pmem[51] = ins(`CPFS_OP_BRANCH, 4'h0, 4'h0, 20'h00033);
		u_cpfs_mem_model.pmem[64] = 32'h5A5A1234;
		u_cpfs_mem_model.pmem[80] = ins(`CPFS_OP_ALU, 4'hA, 4'h0, 20'h00055);
		u_cpfs_mem_model.pmem[81] = ins(`CPFS_OP_BRANCH, 4'h0, 4'h0, 20'h00051);
		u_cpfs_mem_model.dmem[16] = {lfsr(16'h1234), lfsr(16'h4321)};
		u_cpfs_mem_model.dmem[17] = 32'hC0DE0011;
		// second pass resets in mid-run with waits switched on
		for (runPass = 0; runPass < 2; runPass = runPass + 1) begin
			@(posedge clock);
			#1 rst = 1'b1;
			repeat (8) @(posedge clock);
			#1 rst = 1'b0;
			build_expect;
			cyc = 0;
			while ((qCmd.size() > 0 || qWr.size() > 0) && cyc < 3000) begin
				@(posedge clock);
				cyc = cyc + 1;
			end
			check("stream left", qCmd.size() + qWr.size(), 0);
			check("repeat count", {24'h000000, repeatCount}, 32'h00000000);
			$display("program pass %0d done", runPass);
		end
		@(posedge clock);
		#1 interruptReq = 1'b1;
		cyc = 0;
		while (seenIrq !== 1'b1 && cyc < 200) begin
			@(posedge clock);
			cyc = cyc + 1;
		end
		check("vector code ran", {31'h00000000, seenIrq}, 32'h00000001);
		#1 interruptReq = 1'b0;
		$display("interrupt test done");
		report_and_stop;
	end
endmodule
